// ---- rtl/bridge_pwm_pkg.sv ----
/*
 * constants shared by the bridge pwm output stage: register offsets,
 * field positions, reset values, output configuration codes, timing counts.
 * assumes a 32-bit apb bus with word-aligned registers.
 */
package bridge_pwm_pkg;

   // ***************************************************************
   // register offsets (byte addresses)
   // ***************************************************************
   localparam logic [7:0] ADDR_UNIT_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SHUTDOWN_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_PWM_DELAY_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_STEERING = 8'h0c;
   localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int CFG_HI = 7;
   localparam int CFG_LO = 6;
   localparam int MODE_HI = 3;
   localparam int MODE_LO = 0;
   localparam int POL_AC_BIT = 1;
   localparam int POL_BD_BIT = 0;
   localparam int SD_STATUS_BIT = 7;
   localparam int SD_SRC_HI = 6;
   localparam int SD_SRC_LO = 4;
   localparam int PSS_AC_HI = 3;
   localparam int PSS_AC_LO = 2;
   localparam int PSS_BD_HI = 1;
   localparam int PSS_BD_LO = 0;
   localparam int RESTART_BIT = 7;
   localparam int STEER_SYNC_BIT = 4;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
   localparam logic [7:0] RST_SHUTDOWN_CONTROL = 8'h00;
   localparam logic [7:0] RST_PWM_DELAY_CONTROL = 8'h00;
   localparam logic [4:0] RST_STEERING = 5'h01;
   localparam logic [3:0] RST_PIN_DIRECTION = 4'hf;

   // ***************************************************************
   // codes and timing
   // ***************************************************************
   localparam logic [1:0] CFG_SINGLE = 2'h0;
   localparam logic [1:0] CFG_FULL_FWD = 2'h1;
   localparam logic [1:0] CFG_HALF = 2'h2;
   localparam logic [1:0] CFG_FULL_REV = 2'h3;
   localparam logic [1:0] PWM_MODE_SEL = 2'h3;
   localparam logic [1:0] PSS_DRIVE_LOW = 2'h0;
   localparam logic [1:0] PSS_DRIVE_HIGH = 2'h1;
   localparam int OSC_PER_INSTR = 4;
   localparam int DEAD_BAND_W = 7;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} run_e;

endpackage

// ---- rtl/dead_band_delay.sv ----
/*
 * rising-edge delay for one half-bridge output.
 * assumes din is a same-clock level and count is stable during use.
 */
`timescale 1ns/1ps
module dead_band_delay
   import bridge_pwm_pkg::*;
#(
   parameter int W = DEAD_BAND_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic din,
   input wire logic [W-1:0] count,
   output logic dout
);

   typedef struct packed {
      logic [W+1:0] cnt;
      logic out;
   } db_s;

   db_s s;
   db_s next_s;
   logic [W+1:0] limit;

   // one count is one instruction cycle of OSC_PER_INSTR clocks
   assign limit = (W+2)'(count * OSC_PER_INSTR);

   always_comb
   begin
      next_s = s;
      if (!din)
      begin
         // falling edge is never delayed
         next_s.cnt = '0;
         next_s.out = 1'b0;
      end
      else if (s.cnt >= limit)
      begin
         next_s.out = 1'b1; // RULE8
      end
      else
      begin
         next_s.cnt = s.cnt + 1'b1; // RULE9
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign dout = s.out;

   property p_db_needs_input;
      @(posedge pclk) disable iff (!presetn)
      $rose(s.out) |-> $past(din) && $past(s.cnt) >= $past(limit);
   endproperty
   a_db_needs_input: assert property (p_db_needs_input) else $error("dead band ended early"); // RULE8

endmodule

// ---- rtl/bridge_pwm_output.sv ----
/*
 * enhanced pwm output stage: steers a base pwm waveform onto four pins in
 * single, half-bridge or full-bridge mode, with dead band, polarity and
 * auto-shutdown, configured over apb.
 * assumes pwm_base, period_start and period_last_tick come from a period
 * timer on pclk; period_last_tick leads period_start by one timer tick.
 */
`timescale 1ns/1ps
// Summary of operation
// RULE1: all timing counts pclk, so output frequency scales with the clock.
// RULE2: reset restores registers and leaves all four pins undriven.
// RULE3: config field 10 half, 01 forward, 11 reverse, 00 single output.
// RULE4: after enabling, outputs wait for the next period start.
// RULE5: zero in unit control releases all four pins.
// RULE6: unused pins stay free; single mode uses steering enables per pin.
// RULE7: half-bridge puts pwm on A, its complement on B.
// RULE8: half-bridge active edges delayed by dead band count times four clocks.
// RULE9: dead band longer than the active time keeps that output inactive.
// RULE10: forward mode: A active, D modulated, B and C inactive.
// RULE11: reverse mode: C active, B modulated, A and D inactive.
// RULE12: direction change blanks modulated pins, swaps others, resumes next period.
// RULE13: unmodulated pins swap one prescaled clock before the period ends.
// RULE14: no dead band in full-bridge modes.
// RULE15: mode low bits pick polarity for pair A/C and pair B/D.
// RULE16: software picks polarity before enabling pin drivers.
// RULE17: software waits one full period before enabling pin drivers.
// RULE18: software follows the documented setup order.
// RULE19: shutdown from int pin low, comparator one, comparator two, or software.
// RULE20: shutdown sets the status bit until cleared or auto restart.
// RULE21: shutdown forces enabled pins to their shutdown state.
// RULE22: each pin pair is driven high, driven low or released in shutdown.
// RULE23: pair state 00 low, 01 high, 1x high impedance.
// RULE24: source select bits OR comparator one, comparator two, int pin low.
// RULE25: condition is a level; status writes ignored; restart at period start.
// RULE26: restart enable clears status by hardware once the condition is gone.
// RULE27: mode and direction take effect on period start boundaries.
module bridge_pwm_output
   import bridge_pwm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pwm_base,
   input wire logic period_start,
   input wire logic period_last_tick,
   input wire logic comparator_one,
   input wire logic comparator_two,
   input wire logic int_pin_n,
   output logic pwm_out_a,
   output logic pwm_out_b,
   output logic pwm_out_c,
   output logic pwm_out_d,
   output logic pwm_oe_a,
   output logic pwm_oe_b,
   output logic pwm_oe_c,
   output logic pwm_oe_d
);

   typedef struct packed {
      logic [7:0] unit_control_register;
      logic [7:0] shutdown_control;
      logic [7:0] pwm_delay_control;
      logic [4:0] steering;
      logic [3:0] pin_direction_bit;
      logic [3:0] steer_act;
      logic [1:0] cfg_act;
      run_e run;
      logic dir_chg;
      logic sd_hold;
      logic [1:0] cmp1_sync;
      logic [1:0] cmp2_sync;
      logic [1:0] int_sync;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
      logic [3:0] pin;
      logic [3:0] oe;
   } state_s;

   state_s s;
   state_s next_s;
   logic [1:0] db_in;
   logic [1:0] db_out;
   logic pwm_on;
   logic sd_cond;
   logic sd_act;
   logic setup;
   logic wr;
   logic mapped;
   logic [3:0] lg;
   logic [3:0] own;
   logic [3:0] pol;
   logic [31:0] rd;
   logic [1:0] cfg_req;
   logic [2:0] src;
   logic [1:0] pss;

   // ***************************************************************
   // dead band for the two half-bridge outputs
   // ***************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_db
         dead_band_delay #(.W(DEAD_BAND_W)) u_db (
            .pclk(pclk),
            .presetn(presetn),
            .din(db_in[gi]),
            .count(s.pwm_delay_control[DEAD_BAND_W-1:0]),
            .dout(db_out[gi])
         );
      end
   endgenerate

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb
   begin
      next_s = s;
      pss = '0;
      cfg_req = s.unit_control_register[CFG_HI:CFG_LO];
      pwm_on = s.unit_control_register[MODE_HI:MODE_HI-1] == PWM_MODE_SEL;
      src = s.shutdown_control[SD_SRC_HI:SD_SRC_LO];
      setup = psel && !penable;
      wr = psel && penable && s.ready && pwrite;

      // only the second stage of each synchroniser is read
      next_s.cmp1_sync = {s.cmp1_sync[0], comparator_one};
      next_s.cmp2_sync = {s.cmp2_sync[0], comparator_two};
      next_s.int_sync = {s.int_sync[0], int_pin_n};
      sd_cond = (src[0] && s.cmp1_sync[1]) || (src[1] && s.cmp2_sync[1])
         || (src[2] && !s.int_sync[1]); // RULE19 RULE24
      sd_act = s.shutdown_control[SD_STATUS_BIT] || s.sd_hold;

      // apb: zero wait states, answer prepared in the setup cycle
      mapped = 1'b1;
      rd = '0;
      case (paddr)
         ADDR_UNIT_CONTROL: rd[7:0] = s.unit_control_register;
         ADDR_SHUTDOWN_CONTROL: rd[7:0] = s.shutdown_control;
         ADDR_PWM_DELAY_CONTROL: rd[7:0] = s.pwm_delay_control;
         ADDR_STEERING: rd[4:0] = s.steering;
         ADDR_PIN_DIRECTION: rd[3:0] = s.pin_direction_bit;
         ADDR_STATUS: rd[7:0] = {sd_cond, s.sd_hold, s.cfg_act, s.dir_chg, s.run == ST_RUN, s.run == ST_ARMED, pwm_on};
         default: mapped = 1'b0;
      endcase
      next_s.ready = setup;
      next_s.slverr = setup && !mapped;
      next_s.rdata = (setup && !pwrite && mapped) ? rd : '0;

      if (wr)
      begin
         case (paddr)
            ADDR_UNIT_CONTROL: next_s.unit_control_register = pwdata[7:0];
            ADDR_SHUTDOWN_CONTROL: next_s.shutdown_control[SD_SRC_HI:0] = pwdata[SD_SRC_HI:0];
            ADDR_PWM_DELAY_CONTROL: next_s.pwm_delay_control = pwdata[7:0];
            ADDR_STEERING: next_s.steering = pwdata[4:0];
            ADDR_PIN_DIRECTION: next_s.pin_direction_bit = pwdata[3:0];
            default: next_s.unit_control_register = s.unit_control_register;
         endcase
      end

      // ***************************************************************
      // shutdown status: auto clear, then software, then the event wins
      // ***************************************************************
      if (s.pwm_delay_control[RESTART_BIT] && !sd_cond)
         next_s.shutdown_control[SD_STATUS_BIT] = 1'b0; // RULE26
      if (wr && paddr == ADDR_SHUTDOWN_CONTROL && !sd_cond)
         next_s.shutdown_control[SD_STATUS_BIT] = pwdata[SD_STATUS_BIT]; // RULE25
      if (sd_cond)
         next_s.shutdown_control[SD_STATUS_BIT] = 1'b1; // RULE20
      // output stays in shutdown until a period boundary after clearing
      if (s.shutdown_control[SD_STATUS_BIT])
         next_s.sd_hold = 1'b1;
      else if (period_start)
         next_s.sd_hold = 1'b0; // RULE25

      // ***************************************************************
      // run state and period-boundary updates
      // ***************************************************************
      if (!s.steering[STEER_SYNC_BIT])
         next_s.steer_act = s.steering[3:0];
      case (s.run)
         ST_IDLE:
            if (pwm_on)
               next_s.run = ST_ARMED;
         ST_ARMED, ST_RUN:
            if (period_start)
               next_s.run = ST_RUN; // RULE4
         default: next_s.run = ST_IDLE;
      endcase
      if (!pwm_on)
         next_s.run = ST_IDLE;
      if (period_start)
      begin
         next_s.cfg_act = cfg_req; // RULE27
         next_s.dir_chg = 1'b0;
         if (s.steering[STEER_SYNC_BIT])
            next_s.steer_act = s.steering[3:0];
      end
      else if (s.run == ST_RUN && period_last_tick && s.cfg_act[0] && cfg_req[0]
         && cfg_req[1] != s.cfg_act[1])
         next_s.dir_chg = 1'b1; // RULE12 RULE13

      // ***************************************************************
      // logical waveform, index 0..3 = A..D, active high
      // ***************************************************************
      lg = '0;
      db_in = '0;
      if (s.run == ST_RUN)
      begin
         case (s.cfg_act)
            CFG_SINGLE: lg = {4{pwm_base}}; // RULE3
            CFG_HALF:
            begin
               db_in = {!pwm_base, pwm_base};
               lg[1:0] = db_out; // RULE7 RULE8
            end
            CFG_FULL_FWD: lg = {pwm_base && !s.dir_chg, 1'b0, 1'b0, 1'b1}; // RULE10 RULE14
            CFG_FULL_REV: lg = {1'b0, 1'b1, pwm_base && !s.dir_chg, 1'b0}; // RULE11 RULE14
            default: lg = '0;
         endcase
         if (s.dir_chg)
            lg[2:0] = (s.cfg_act == CFG_FULL_FWD) ? 3'h4 : 3'h1; // RULE12
      end

      // pins owned by the unit; a zero control register releases all
      case (cfg_req)
         CFG_SINGLE: own = s.steer_act; // RULE6
         CFG_HALF: own = 4'h3; // RULE6
         default: own = 4'hf;
      endcase
      if (s.unit_control_register == 8'h00 || !pwm_on)
         own = '0; // RULE5

      pol = {s.unit_control_register[POL_BD_BIT], s.unit_control_register[POL_AC_BIT],
         s.unit_control_register[POL_BD_BIT], s.unit_control_register[POL_AC_BIT]};
      next_s.pin = lg ^ pol; // RULE15
      next_s.oe = own & ~s.pin_direction_bit;

      // pair A/C uses pins 0 and 2, pair B/D pins 1 and 3
      if (sd_act)
      begin
         for (int i = 0; i < 4; i++)
         begin
            pss = (i % 2 == 0) ? s.shutdown_control[PSS_AC_HI:PSS_AC_LO]
               : s.shutdown_control[PSS_BD_HI:PSS_BD_LO];
            if (own[i])
            begin
               next_s.pin[i] = (pss == PSS_DRIVE_HIGH); // RULE21 RULE22 RULE23
               if (pss[1])
                  next_s.oe[i] = 1'b0; // RULE23
            end
         end
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0; // RULE2
         s.unit_control_register <= RST_UNIT_CONTROL;
         s.shutdown_control <= RST_SHUTDOWN_CONTROL;
         s.pwm_delay_control <= RST_PWM_DELAY_CONTROL;
         s.steering <= RST_STEERING;
         s.pin_direction_bit <= RST_PIN_DIRECTION;
         s.steer_act <= RST_STEERING[3:0];
         s.run <= ST_IDLE;
         s.int_sync <= 2'h3;
      end
      else
         s <= next_s; // RULE1
   end

   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.slverr;
   assign {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} = s.pin;
   assign {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} = s.oe;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_release;
      @(posedge pclk) disable iff (!presetn)
      s.unit_control_register == 8'h00 |=> s.oe == 4'h0;
   endproperty
   a_release: assert property (p_release) else $error("pins driven with unit off"); // RULE5

   property p_wait_period;
      @(posedge pclk) disable iff (!presetn)
      s.run == ST_ARMED && !sd_act |=> pwm_out_a == $past(s.unit_control_register[POL_AC_BIT]);
   endproperty
   a_wait_period: assert property (p_wait_period) else $error("output before period start"); // RULE4

   property p_forward;
      @(posedge pclk) disable iff (!presetn)
      s.run == ST_RUN && s.cfg_act == CFG_FULL_FWD && !s.dir_chg && !sd_act
      |=> pwm_out_a != $past(s.unit_control_register[POL_AC_BIT])
      && pwm_out_b == $past(s.unit_control_register[POL_BD_BIT]);
   endproperty
   a_forward: assert property (p_forward) else $error("forward pattern wrong"); // RULE10

   property p_reverse;
      @(posedge pclk) disable iff (!presetn)
      s.run == ST_RUN && s.cfg_act == CFG_FULL_REV && !s.dir_chg && !sd_act
      |=> pwm_out_c != $past(s.unit_control_register[POL_AC_BIT])
      && pwm_out_a == $past(s.unit_control_register[POL_AC_BIT]);
   endproperty
   a_reverse: assert property (p_reverse) else $error("reverse pattern wrong"); // RULE11

   // b drops two cycles after pwm rises: its release passes the delay register and the pin register
   property p_half_complement;
      @(posedge pclk) disable iff (!presetn)
      s.run == ST_RUN && s.cfg_act == CFG_HALF && pwm_base && $past(pwm_base) && !sd_act
      |=> pwm_out_b == $past(s.unit_control_register[POL_BD_BIT]);
   endproperty
   a_half_complement: assert property (p_half_complement) else $error("half bridge overlap"); // RULE7

   property p_sd_set;
      @(posedge pclk) disable iff (!presetn)
      sd_cond |=> s.shutdown_control[SD_STATUS_BIT] ##1 s.sd_hold;
   endproperty
   a_sd_set: assert property (p_sd_set) else $error("shutdown status not set"); // RULE20

   property p_auto_restart;
      @(posedge pclk) disable iff (!presetn)
      s.pwm_delay_control[RESTART_BIT] && !sd_cond && !wr |=> !s.shutdown_control[SD_STATUS_BIT];
   endproperty
   a_auto_restart: assert property (p_auto_restart) else $error("auto restart did not clear"); // RULE26

   property p_sd_high;
      @(posedge pclk) disable iff (!presetn)
      sd_act && own[0] && s.shutdown_control[PSS_AC_HI:PSS_AC_LO] == PSS_DRIVE_HIGH
      |=> pwm_out_a && pwm_oe_a == !$past(s.pin_direction_bit[0]);
   endproperty
   a_sd_high: assert property (p_sd_high) else $error("shutdown drive high wrong"); // RULE22

   property p_dir_change;
      @(posedge pclk) disable iff (!presetn)
      s.dir_chg && s.cfg_act == CFG_FULL_FWD && !sd_act |=> pwm_out_d == $past(s.unit_control_register[POL_BD_BIT])
      && pwm_out_a == $past(s.unit_control_register[POL_AC_BIT]);
   endproperty
   a_dir_change: assert property (p_dir_change) else $error("direction change pattern wrong"); // RULE12

endmodule

// ---- verif/period_source.sv ----
/*
 * stand-in for the period timer and duty comparator that feed the output stage.
 * assumes a 1:1 prescale, so the last tick leads the period start by one pclk.
 */
`timescale 1ns/1ps
module period_source
#(
   parameter int PER = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] duty,
   output logic pwm_base,
   output logic period_start,
   output logic period_last_tick
);
   logic [7:0] cnt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt <= 8'h00;
      else if (cnt == 8'(PER - 1))
         cnt <= 8'h00;
      else
         cnt <= cnt + 8'h01;
   end

   assign period_start = (cnt == 8'h00);
   assign period_last_tick = (cnt == 8'(PER - 1));
   assign pwm_base = (cnt < duty);
endmodule

// ---- verif/tb_top.sv ----
/*
 * self-checking bench for the bridge pwm output stage.
 * assumes a 16-clock period with half duty from period_source.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         failures++; \
         $display("BAD %s exp=%h got=%h", nm, e, g); \
      end \
   end
module tb_top;
   import bridge_pwm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, duty;
   logic [31:0] pwdata, prdata, r;
   logic pwm_base, period_start, period_last_tick;
   logic comparator_one, comparator_two, int_pin_n, e;
   logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
   logic pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d;
   logic [3:0] pins, oes;
   logic [19:0] row;
   logic [1:0] seen;
   int failures, tests_run;
   // rows: unit control, pins in high phase, pins in low phase, enables
   localparam logic [19:0] ROWS [7] = '{20'h0cf0f, 20'h8c123, 20'h4c91f, 20'hcc64f,
                                        20'h8f213, 20'h4ec4f, 20'h0d5af};
   assign pins = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
   assign oes = {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a};

   bridge_pwm_output u_bridge_pwm_output (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_base(pwm_base), .period_start(period_start),
      .period_last_tick(period_last_tick), .comparator_one(comparator_one),
      .comparator_two(comparator_two), .int_pin_n(int_pin_n), .pwm_out_a(pwm_out_a),
      .pwm_out_b(pwm_out_b), .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d), .pwm_oe_a(pwm_oe_a),
      .pwm_oe_b(pwm_oe_b), .pwm_oe_c(pwm_oe_c), .pwm_oe_d(pwm_oe_d));
   period_source u_period_source (.pclk(pclk), .presetn(presetn), .duty(duty),
      .pwm_base(pwm_base), .period_start(period_start), .period_last_tick(period_last_tick));

   // ***************************************************************
   // bus and timing helpers
   // ***************************************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here: the watchdog ends a hang
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic err;
      apb(1'b1, a, d, q, err);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic err;
      apb(1'b0, a, 32'h0, q, err);
   endtask

   // n clocks past the next period start, then let that edge settle
   task automatic at(input int n);
      do
         @(posedge pclk);
      while (period_start !== 1'b1);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // drivers off, mode in, one full period, then drivers on
   task automatic set_mode(input logic [7:0] ctl);
      wr(ADDR_PIN_DIRECTION, 32'hf);
      wr(ADDR_UNIT_CONTROL, {24'h0, ctl});
      at(0);
      at(0);
      wr(ADDR_PIN_DIRECTION, 32'h0);
   endtask

   task automatic set_src(input int i, input logic on);
      @(posedge pclk);
      comparator_one <= on & (i == 0);
      comparator_two <= on & (i == 1);
      int_pin_n <= !(on & (i == 2));
   endtask

   task stop_test;
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always #2 pclk = ~pclk;

   initial
   begin
      #100000;
      failures++;
      stop_test();
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      failures = 0;
      tests_run = 0;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {comparator_one, comparator_two, int_pin_n} = 3'b001;
      duty = 8'h08;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wr(ADDR_STEERING, 32'h0f);
      for (int i = 0; i < 7; i++)
      begin
         row = ROWS[i];
         set_mode(row[19:12]);
         at(5);
         `CHK("enables", row[3:0], oes);
         `CHK("high phase", row[11:8] & row[3:0], pins & oes);
         at(13);
         `CHK("low phase", row[7:4] & row[3:0], pins & oes);
      end
      wr(ADDR_STEERING, 32'h05);
      repeat (2) @(posedge pclk);
      #1;
      `CHK("steered", 4'h5, oes);
      wr(ADDR_STEERING, 32'h0f);
      // dead band in half-bridge
      set_mode(8'h8c);
      wr(ADDR_PWM_DELAY_CONTROL, 32'h01);
      at(3);
      `CHK("db early", 1'b0, pwm_out_a);
      at(7);
      `CHK("db late", 1'b1, pwm_out_a);
      wr(ADDR_PWM_DELAY_CONTROL, 32'h07);
      at(0);
      seen = 2'b00;
      repeat (16)
      begin
         @(posedge pclk);
         #1;
         seen = seen | pins[1:0];
      end
      `CHK("db swallowed", 2'b00, seen);
      // direction change, with a dead band that full-bridge must ignore
      set_mode(8'h4c);
      at(3);
      wr(ADDR_UNIT_CONTROL, 32'hcc);
      at(0);
      `CHK("swap", 4'h4, pins);
      at(5);
      `CHK("resumed", 4'h6, pins);
      wr(ADDR_PWM_DELAY_CONTROL, 32'h0);
      // shutdown: a/c driven low, b/d released
      set_mode(8'h4c);
      wr(ADDR_SHUTDOWN_CONTROL, 32'h02);
      set_src(0, 1'b1);
      repeat (8) @(posedge pclk);
      rd(ADDR_SHUTDOWN_CONTROL, r);
      `CHK("no source", 1'b0, r[7]);
      set_src(0, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR_SHUTDOWN_CONTROL, 32'h02 | (32'h10 << i));
         set_src(i, 1'b1);
         repeat (8) @(posedge pclk);
         #1;
         `CHK("sd enables", 4'h5, oes);
         `CHK("sd levels", 4'h0, pins & oes);
         rd(ADDR_SHUTDOWN_CONTROL, r);
         `CHK("sd set", 1'b1, r[7]);
         wr(ADDR_SHUTDOWN_CONTROL, 32'h02 | (32'h10 << i));
         rd(ADDR_SHUTDOWN_CONTROL, r);
         `CHK("sd held", 1'b1, r[7]);
         set_src(i, 1'b0);
         repeat (8) @(posedge pclk);
         rd(ADDR_SHUTDOWN_CONTROL, r);
         `CHK("sd latched", 1'b1, r[7]);
         wr(ADDR_SHUTDOWN_CONTROL, 32'h02 | (32'h10 << i));
         at(0);
         at(5);
         `CHK("sd resume", 4'h9, pins);
      end
      wr(ADDR_PWM_DELAY_CONTROL, 32'h80);
      wr(ADDR_SHUTDOWN_CONTROL, 32'h12);
      set_src(0, 1'b1);
      repeat (8) @(posedge pclk);
      set_src(0, 1'b0);
      repeat (8) @(posedge pclk);
      rd(ADDR_SHUTDOWN_CONTROL, r);
      `CHK("auto clear", 1'b0, r[7]);
      at(0);
      at(5);
      `CHK("auto resume", 4'h9, pins);
      wr(ADDR_PWM_DELAY_CONTROL, 32'h0);
      wr(ADDR_SHUTDOWN_CONTROL, 32'h86);
      repeat (6) @(posedge pclk);
      #1;
      `CHK("sw shutdown", 4'h5, oes);
      `CHK("sd high", 4'h5, pins & oes);
      wr(ADDR_SHUTDOWN_CONTROL, 32'h02);
      // release, late start, bus refusal, reset
      wr(ADDR_UNIT_CONTROL, 32'h0);
      repeat (4) @(posedge pclk);
      #1;
      `CHK("released", 4'h0, oes);
      at(2);
      wr(ADDR_UNIT_CONTROL, 32'h4c);
      repeat (2) @(posedge pclk);
      #1;
      `CHK("held off", 1'b0, pwm_out_a & pwm_oe_a);
      apb(1'b0, 8'h1c, 32'h0, r, e);
      `CHK("unmapped err", 1'b1, e);
      `CHK("unmapped data", 32'h0, r);
      at(0);
      at(5);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      `CHK("reset enables", 4'h0, oes);
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_UNIT_CONTROL, r);
      `CHK("rst unit", {24'h0, RST_UNIT_CONTROL}, r);
      rd(ADDR_SHUTDOWN_CONTROL, r);
      `CHK("rst shutdown", {24'h0, RST_SHUTDOWN_CONTROL}, r);
      rd(ADDR_PWM_DELAY_CONTROL, r);
      `CHK("rst delay", {24'h0, RST_PWM_DELAY_CONTROL}, r);
      rd(ADDR_STEERING, r);
      `CHK("rst steering", {27'h0, RST_STEERING}, r);
      rd(ADDR_PIN_DIRECTION, r);
      `CHK("rst direction", {28'h0, RST_PIN_DIRECTION}, r);
      stop_test();
   end
endmodule
